// *** verilog/rtcsp_pkg.sv ***
// Constants and types shared by the RTC status and event-pin block
`default_nettype none
package rtcsp_pkg;
   // Oscillator timebase and pulse lengths
   localparam int          OSC_HZ       = 32768;
   localparam int          PULSE_US     = 7900;
   localparam int          SAMPLE_US    = 15600;
   localparam logic [8:0]  PULSE_TICKS  = 9'(PULSE_US * OSC_HZ / 1000000);
   localparam logic [8:0]  SAMPLE_TICKS = 9'(SAMPLE_US * OSC_HZ / 1000000);
   localparam logic [14:0] DIV_LAST     = 15'h7fff;
   // Register indices
   localparam logic [4:0]  REG_STATUS1  = 5'h00;
   localparam logic [4:0]  REG_STATUS2  = 5'h01;
   localparam logic [4:0]  REG_YEAR     = 5'h02;
   localparam logic [4:0]  REG_MONTH    = 5'h03;
   localparam logic [4:0]  REG_DAY      = 5'h04;
   localparam logic [4:0]  REG_WDAY     = 5'h05;
   localparam logic [4:0]  REG_HOUR     = 5'h06;
   localparam logic [4:0]  REG_MINUTE   = 5'h07;
   localparam logic [4:0]  REG_SECOND   = 5'h08;
   localparam logic [4:0]  REG_PIN_A    = 5'h09;
   localparam logic [4:0]  REG_PIN_B    = 5'h0c;
   localparam logic [4:0]  REG_CORR     = 5'h0f;
   localparam logic [4:0]  REG_FREE     = 5'h10;
   // Field positions
   localparam int          S1_POWER_ON  = 0;
   localparam int          S1_LOW_V     = 1;
   localparam int          S1_H24       = 6;
   localparam int          S1_INIT      = 7;
   localparam int          S2_B_ALARM   = 1;
   localparam int          S2_B_MINUTE  = 2;
   localparam int          S2_B_FREQ    = 3;
   localparam int          S2_A_XTAL    = 4;
   localparam int          S2_A_ALARM   = 5;
   localparam int          S2_A_MINUTE  = 6;
   localparam int          S2_A_FREQ    = 7;
   localparam int          HOUR_PM      = 1;
   localparam int          ALM_VALID    = 0;
   // Reset values
   localparam logic [7:0]  S2_POR       = 8'h80;
   localparam logic [7:0]  FREQ_POR     = 8'h80;
   localparam logic [3:0]  DEF_MONTH    = 4'h1;
   localparam logic [4:0]  DEF_DAY      = 5'h01;
   // Calendar limits
   localparam logic [5:0]  SEC_MAX      = 6'h3b;
   localparam logic [5:0]  SEC_HALF     = 6'h1e;
   localparam logic [4:0]  HOUR_MAX     = 5'h17;
   localparam logic [4:0]  HOUR_NOON    = 5'h0c;
   localparam logic [3:0]  MONTH_MAX    = 4'hc;
   localparam logic [6:0]  YEAR_MAX     = 7'h63;
   localparam logic [2:0]  WDAY_MAX     = 3'h6;

   typedef struct packed {
      logic xtal;
      logic alarm;
      logic minute;
      logic freq;
   } rtcsp_mode_t;
endpackage
`default_nettype wire

// *** verilog/rtcsp_top.sv ***
// Status, supervision, calendar repair and event-pin logic of an RTC
//
// The address map and the address-and-strobe port are this design's own decisions.
`default_nettype none
// How it works
// - Power-on clears other registers, loads default calendar
// - Power-on sets flag, pin A outputs 1 Hz
// - Initialization clears power-on flag and frequency mode
// - Initialization restores defaults, keeps status bits 6-4
// - Supply sampled 15.6 ms once per second
// - Low supply sets sticky flag, stops sampling
// - Init or flag read clears it, restarts sampling
// - Invalid date values repaired on write
// - Invalid time values become zero on write
// - Bad seconds fixed at next carry, minute advances
// - Afternoon flag written in 12h, derived in 24h
// - Nonexistent day moves to next month's first
// - Both pins share modes; pin A adds two
// - Alarm pin low until alarm enable cleared
// - Re-enabled alarm stays high during same match
// - Frequency mode ANDs selected frequencies
// - Minute edge low until disabled, 7.9 ms pulse
// - Minute square wave, half low, from carry
// - Pin A pulses 7.9 ms each minute carry
// - Status-2 bits 7-4 pick pin A mode
// - Status-2 bits 3-1 pick pin B mode
// - Init bit write-only, reads back zero
// - Alarm byte bit 0 enables its comparison

module rtcsp_pin
   import rtcsp_pkg::*;
   #(parameter bit HAS_EXTRA = 1'b0)
   (input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire rtcsp_mode_t mode,
    input  wire logic        osc_level,
    input  wire logic        alarm_match,
    input  wire logic        min_tick,
    input  wire logic        pulse_on,
    input  wire logic        first_half,
    input  wire logic        freq_level,
    output logic             pin_out,
    output logic             pin_oe);

   logic edge_low;
   logic started;
   logic alarm_low;
   logic match_q;

   // Mode decode
   wire xtal_m  = HAS_EXTRA && mode.xtal;
   wire freq_m  = !xtal_m && mode.freq && !mode.minute;
   wire edge_m  = !xtal_m && mode.minute && !mode.freq;
   wire per2_m  = HAS_EXTRA && !xtal_m && mode.alarm && mode.minute
                  && mode.freq;
   wire per1_m  = !xtal_m && mode.minute && mode.freq && !per2_m;
   wire alarm_m = !xtal_m && mode.alarm && !mode.minute && !mode.freq;
   wire alarm_fire = alarm_m && alarm_match && !match_q;

   wire next_low = xtal_m  ? !osc_level :
                   freq_m  ? !freq_level :
                   edge_m  ? (edge_low || pulse_on) :
                   per1_m  ? (started && first_half) :
                   per2_m  ? (started && pulse_on) :
                   alarm_m ? alarm_low : 1'b0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edge_low  <= 1'b0;
         started   <= 1'b0;
         alarm_low <= 1'b0;
         match_q   <= 1'b0;
         pin_out   <= 1'b0;
         pin_oe    <= 1'b0;
      end else if (ce) begin
         match_q   <= alarm_match;
         edge_low  <= edge_m && (edge_low || min_tick);
         started   <= (per1_m || per2_m) && (started || min_tick);
         alarm_low <= mode.alarm && (alarm_low || alarm_fire);
         pin_out   <= 1'b0;
         pin_oe    <= next_low;
      end
   end
endmodule

module rtcsp_top
   import rtcsp_pkg::*;
   (input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       osc_32k,
    input  wire logic       supply_low,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            detector_sample,
    output logic            event_pin_a_out,
    output logic            event_pin_a_oe,
    output logic            event_pin_b_out,
    output logic            event_pin_b_oe);

   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      logic [6:0] t;
      t = v / 7'd10;
      to_bcd = {t[3:0], 4'(v - t * 7'd10)};
   endfunction

   function automatic logic [4:0] days_in(input logic [3:0] m,
                                          input logic [6:0] y);
      case (m)
         4'h2: days_in = (y[1:0] == 2'b00) ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
         default: days_in = 5'h1f;
      endcase
   endfunction

   // Synchronisers for the oscillator and the supply detector
   logic        osc_q1;
   logic        osc_q2;
   logic        osc_q3;
   logic        low_q1;
   logic        low_q2;
   // Timebase
   logic [14:0] div;
   logic [8:0]  pulse_cnt;
   logic        min_tick;
   // Calendar, binary
   logic [5:0]  sec;
   logic [5:0]  minute;
   logic [4:0]  hour;
   logic [2:0]  wday;
   logic [4:0]  day;
   logic [3:0]  month;
   logic [6:0]  year;
   logic        sec_bad;
   logic        eom_chk;
   // Status and user registers
   logic        power_on_flag;
   logic        low_voltage_flag;
   logic [2:0]  s1_user;
   logic [7:0]  status2;
   logic [7:0]  pin_a_reg [0:2];
   logic [7:0]  pin_b_reg [0:2];
   logic [7:0]  corr;
   logic [7:0]  free;
   logic [7:0]  next_rdata;

   wire osc_rise = osc_q2 && !osc_q3;
   wire sec_tick = osc_rise && (div == DIV_LAST);
   wire pulse_on = pulse_cnt != 9'h000;
   wire hour24   = s1_user[2];

   // Register decode
   wire do_init  = wr && addr == REG_STATUS1 && wdata[S1_INIT];
   wire wr_s1    = wr && addr == REG_STATUS1;
   wire wr_s2    = wr && addr == REG_STATUS2;
   wire wr_year  = wr && addr == REG_YEAR;
   wire wr_month = wr && addr == REG_MONTH;
   wire wr_day   = wr && addr == REG_DAY;
   wire wr_wday  = wr && addr == REG_WDAY;
   wire wr_hour  = wr && addr == REG_HOUR;
   wire wr_min   = wr && addr == REG_MINUTE;
   wire wr_sec   = wr && addr == REG_SECOND;
   wire wr_corr  = wr && addr == REG_CORR;
   wire wr_free  = wr && addr == REG_FREE;
   wire rd_s1    = rd && addr == REG_STATUS1;
   wire in_a     = addr >= REG_PIN_A && addr < REG_PIN_B;
   wire in_b     = addr >= REG_PIN_B && addr < REG_CORR;
   wire [1:0] idx_a = 2'(addr - REG_PIN_A);
   wire [1:0] idx_b = 2'(addr - REG_PIN_B);

   // Written data checks
   wire [3:0] wd_hi   = wdata[7:4];
   wire [3:0] wd_lo   = wdata[3:0];
   wire       nib_ok  = wd_hi <= 4'h9 && wd_lo <= 4'h9;
   wire [6:0] wd_bin  = {3'b000, wd_hi} * 7'd10 + {3'b000, wd_lo};
   wire       mon_ok  = nib_ok && wd_bin >= 7'h01
                        && wd_bin <= {3'b000, MONTH_MAX};
   wire       day_ok  = nib_ok && wd_bin >= 7'h01 && wd_bin <= 7'h1f;
   wire       ms_ok   = nib_ok && wd_bin <= {1'b0, SEC_MAX};
   wire [3:0] h_units = wdata[5:2];
   wire [6:0] h_bin   = {5'b00000, wdata[7:6]} * 7'd10
                        + {3'b000, h_units};
   wire       h_ok    = h_units <= 4'h9 && (hour24 ?
                        h_bin <= {2'b00, HOUR_MAX} :
                        h_bin < {2'b00, HOUR_NOON});
   wire [4:0] h_new   = !h_ok ? 5'h00 :
                        (!hour24 && wdata[HOUR_PM]) ?
                        5'(h_bin) + HOUR_NOON : 5'(h_bin);

   // Hour presentation
   wire       is_pm   = hour >= HOUR_NOON;
   wire [4:0] h_disp  = (!hour24 && is_pm) ? hour - HOUR_NOON : hour;
   wire [7:0] h_bcd   = to_bcd({2'b00, h_disp});
   wire [7:0] hour_rd = {h_bcd[5:4], h_bcd[3:0], is_pm, 1'b0};
   wire [7:0] min_rd  = to_bcd({1'b0, minute});
   wire [4:0] dim     = days_in(month, year);

   // Alarm comparison per pin
   wire match_a = (pin_a_reg[0][ALM_VALID] || pin_a_reg[1][ALM_VALID]
                   || pin_a_reg[2][ALM_VALID])
                  && (!pin_a_reg[0][ALM_VALID] || pin_a_reg[0][3:1] == wday)
                  && (!pin_a_reg[1][ALM_VALID]
                      || pin_a_reg[1][7:1] == hour_rd[7:1])
                  && (!pin_a_reg[2][ALM_VALID]
                      || pin_a_reg[2][7:1] == min_rd[6:0]);
   wire match_b = (pin_b_reg[0][ALM_VALID] || pin_b_reg[1][ALM_VALID]
                   || pin_b_reg[2][ALM_VALID])
                  && (!pin_b_reg[0][ALM_VALID] || pin_b_reg[0][3:1] == wday)
                  && (!pin_b_reg[1][ALM_VALID]
                      || pin_b_reg[1][7:1] == hour_rd[7:1])
                  && (!pin_b_reg[2][ALM_VALID]
                      || pin_b_reg[2][7:1] == min_rd[6:0]);

   // Frequency taps: bit 14 is 1 Hz down to bit 10 at 16 Hz
   wire freq_a = &(div[14:10] | ~pin_a_reg[0][7:3]);
   wire freq_b = &(div[14:10] | ~pin_b_reg[0][7:3]);
   wire first_half = sec < SEC_HALF;
   wire sample_win = div < {6'h00, SAMPLE_TICKS} && !low_voltage_flag;

   wire rtcsp_mode_t mode_a = '{xtal: status2[S2_A_XTAL],
                                alarm: status2[S2_A_ALARM],
                                minute: status2[S2_A_MINUTE],
                                freq: status2[S2_A_FREQ]};
   wire rtcsp_mode_t mode_b = '{xtal: 1'b0,
                                alarm: status2[S2_B_ALARM],
                                minute: status2[S2_B_MINUTE],
                                freq: status2[S2_B_FREQ]};

   // Sampling and timebase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_q1          <= 1'b0;
         osc_q2          <= 1'b0;
         osc_q3          <= 1'b0;
         low_q1          <= 1'b0;
         low_q2          <= 1'b0;
         div             <= 15'h0000;
         pulse_cnt       <= 9'h000;
         detector_sample <= 1'b0;
      end else if (ce) begin
         osc_q1          <= osc_32k;
         osc_q2          <= osc_q1;
         osc_q3          <= osc_q2;
         low_q1          <= supply_low;
         low_q2          <= low_q1;
         detector_sample <= sample_win;
         if (osc_rise) begin
            div <= div + 15'h0001;
         end
         if (min_tick) begin
            pulse_cnt <= PULSE_TICKS;
         end else if (osc_rise && pulse_on) begin
            pulse_cnt <= pulse_cnt - 9'h001;
         end
      end
   end

   // Calendar with write repair and carries
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec      <= 6'h00;
         minute   <= 6'h00;
         hour     <= 5'h00;
         wday     <= 3'h0;
         day      <= DEF_DAY;
         month    <= DEF_MONTH;
         year     <= 7'h00;
         sec_bad  <= 1'b0;
         eom_chk  <= 1'b0;
         min_tick <= 1'b0;
      end else if (ce) begin
         min_tick <= 1'b0;
         eom_chk  <= 1'b0;
         if (do_init) begin
            sec     <= 6'h00;
            minute  <= 6'h00;
            hour    <= 5'h00;
            wday    <= 3'h0;
            day     <= DEF_DAY;
            month   <= DEF_MONTH;
            year    <= 7'h00;
            sec_bad <= 1'b0;
         end else if (wr_year) begin
            year    <= nib_ok ? wd_bin : 7'h00;
            eom_chk <= 1'b1;
         end else if (wr_month) begin
            month   <= mon_ok ? wd_bin[3:0] : DEF_MONTH;
            eom_chk <= 1'b1;
         end else if (wr_day) begin
            day     <= day_ok ? wd_bin[4:0] : DEF_DAY;
            eom_chk <= 1'b1;
         end else if (wr_wday) begin
            wday <= (wdata[2:0] > WDAY_MAX) ? 3'h0 : wdata[2:0];
         end else if (wr_hour) begin
            hour <= h_new;
         end else if (wr_min) begin
            minute <= ms_ok ? wd_bin[5:0] : 6'h00;
         end else if (wr_sec) begin
            sec     <= ms_ok ? wd_bin[5:0] : 6'h00;
            sec_bad <= !ms_ok;
         end else if (eom_chk && day > dim) begin
            day <= DEF_DAY;
            if (month == MONTH_MAX) begin
               month <= DEF_MONTH;
               year  <= (year == YEAR_MAX) ? 7'h00 : year + 7'h01;
            end else begin
               month <= month + 4'h1;
            end
         end else if (sec_tick) begin
            if (sec_bad || sec == SEC_MAX) begin
               sec      <= 6'h00;
               sec_bad  <= 1'b0;
               min_tick <= 1'b1;
               if (minute == SEC_MAX) begin
                  minute <= 6'h00;
                  if (hour == HOUR_MAX) begin
                     hour <= 5'h00;
                     wday <= (wday == WDAY_MAX) ? 3'h0 : wday + 3'h1;
                     if (day >= dim) begin
                        day <= DEF_DAY;
                        if (month == MONTH_MAX) begin
                           month <= DEF_MONTH;
                           year  <= (year == YEAR_MAX) ? 7'h00
                                    : year + 7'h01;
                        end else begin
                           month <= month + 4'h1;
                        end
                     end else begin
                        day <= day + 5'h01;
                     end
                  end else begin
                     hour <= hour + 5'h01;
                  end
               end else begin
                  minute <= minute + 6'h01;
               end
            end else begin
               sec <= sec + 6'h01;
            end
         end
      end
   end

   // Status and user registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_on_flag    <= 1'b1;
         low_voltage_flag <= 1'b0;
         s1_user          <= 3'h0;
         status2          <= S2_POR;
         pin_a_reg        <= '{FREQ_POR, 8'h00, 8'h00};
         pin_b_reg        <= '{8'h00, 8'h00, 8'h00};
         corr             <= 8'h00;
         free             <= 8'h00;
      end else if (ce) begin
         if (do_init) begin
            power_on_flag    <= 1'b0;
            low_voltage_flag <= 1'b0;
            status2          <= 8'h00;
            pin_a_reg        <= '{8'h00, 8'h00, 8'h00};
            pin_b_reg        <= '{8'h00, 8'h00, 8'h00};
            corr             <= 8'h00;
            free             <= 8'h00;
         end else begin
            if (low_q2 && sample_win) begin
               low_voltage_flag <= 1'b1;
            end else if (rd_s1) begin
               low_voltage_flag <= 1'b0;
            end
            if (wr_s1) begin
               s1_user <= wdata[6:4];
            end
            if (wr_s2) begin
               status2 <= wdata;
            end
            if (wr && in_a) begin
               pin_a_reg[idx_a] <= wdata;
            end
            if (wr && in_b) begin
               pin_b_reg[idx_b] <= wdata;
            end
            if (wr_corr) begin
               corr <= wdata;
            end
            if (wr_free) begin
               free <= wdata;
            end
         end
      end
   end

   // Read selection
   always_comb begin
      next_rdata = 8'h00;
      case (addr)
         REG_STATUS1: next_rdata = {1'b0, s1_user, 2'b00,
                                    low_voltage_flag, power_on_flag};
         REG_STATUS2: next_rdata = status2;
         REG_YEAR:    next_rdata = to_bcd(year);
         REG_MONTH:   next_rdata = to_bcd({3'b000, month});
         REG_DAY:     next_rdata = to_bcd({2'b00, day});
         REG_WDAY:    next_rdata = {5'h00, wday};
         REG_HOUR:    next_rdata = hour_rd;
         REG_MINUTE:  next_rdata = min_rd;
         REG_SECOND:  next_rdata = to_bcd({1'b0, sec});
         5'h09, 5'h0a, 5'h0b: next_rdata = pin_a_reg[idx_a];
         5'h0c, 5'h0d, 5'h0e: next_rdata = pin_b_reg[idx_b];
         REG_CORR:    next_rdata = corr;
         REG_FREE:    next_rdata = free;
         default:     next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (ce && rd) begin
         rdata <= next_rdata;
      end
   end

   rtcsp_pin #(.HAS_EXTRA(1'b1)) u_pin_a (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .mode        (mode_a),
      .osc_level   (osc_q2),
      .alarm_match (match_a),
      .min_tick    (min_tick),
      .pulse_on    (pulse_on),
      .first_half  (first_half),
      .freq_level  (freq_a),
      .pin_out     (event_pin_a_out),
      .pin_oe      (event_pin_a_oe));

   rtcsp_pin #(.HAS_EXTRA(1'b0)) u_pin_b (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .mode        (mode_b),
      .osc_level   (osc_q2),
      .alarm_match (match_b),
      .min_tick    (min_tick),
      .pulse_on    (pulse_on),
      .first_half  (first_half),
      .freq_level  (freq_b),
      .pin_out     (event_pin_b_out),
      .pin_oe      (event_pin_b_oe));
endmodule
`default_nettype wire

// *** dv/rtcsp_monitor.sv ***
// Port checker for the RTC status and event-pin block
`default_nettype none
module rtcsp_monitor
   import rtcsp_pkg::*;
   (input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       event_pin_a_out,
    input wire logic       event_pin_a_oe,
    input wire logic       event_pin_b_out,
    input wire logic       event_pin_b_oe);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   function automatic logic ok59(input logic [7:0] b);
      return b[7:4] <= 4'h5 && b[3:0] <= 4'h9;
   endfunction
   sequence wr_rd(logic [4:0] a);
      wr && ce && addr == a ##2 rd && ce && addr == a;
   endsequence
   sequence s2_wr;
      wr && ce && addr == REG_STATUS2;
   endsequence
   a_pins_open_drain: assert property (
      !event_pin_a_out && !event_pin_b_out)
      else $error("pin data not low");
   a_init_reads_zero: assert property (
      rd && ce && addr == REG_STATUS1 |=> !rdata[S1_INIT])
      else $error("init bit read as one");
   a_pin_b_reset: assert property (
      $fell(rst) |-> !event_pin_b_oe)
      else $error("pin b active after reset");
   a_minute_repair: assert property (
      wr_rd(REG_MINUTE) |=>
      rdata == (ok59($past(wdata, 3)) ? $past(wdata, 3) : 8'h00))
      else $error("minute repair wrong");
   a_wday_repair: assert property (
      wr_rd(REG_WDAY) ##0 $past(wdata, 2) < 8'h08 |=>
      rdata == ($past(wdata, 3) == 8'h07 ? 8'h00 : $past(wdata, 3)))
      else $error("weekday repair wrong");
   a_pin_b_off: assert property (
      s2_wr ##0 wdata[3:1] == 3'h0 |-> ##3 !event_pin_b_oe)
      else $error("pin b active with no mode");
   a_pin_a_off: assert property (
      s2_wr ##0 wdata[7:4] == 4'h0 |-> ##3 !event_pin_a_oe)
      else $error("pin a active with no mode");
   a_edge_waits: assert property (
      s2_wr ##0 wdata[7:4] == 4'h4 |-> ##3 !event_pin_a_oe)
      else $error("edge mode fired before carry");
endmodule
bind rtcsp_top rtcsp_monitor u_mon (.clk, .rst, .ce, .addr, .wdata, .wr,
   .rd, .rdata, .event_pin_a_out, .event_pin_a_oe, .event_pin_b_out,
   .event_pin_b_oe);
`default_nettype wire

// *** dv/rtcsp_osc_model.sv ***
// Crystal and supply comparator model at the block's far side
`default_nettype none
module rtcsp_osc_model
   (input  wire logic low_req,
    output logic      osc_32k,
    output logic      supply_low);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      osc_32k = 1'b0;
      #3.3;
      forever #62.5 osc_32k = ~osc_32k;
   end
   assign supply_low = low_req;
endmodule
`default_nettype wire

// *** dv/rtcsp_top_bench.sv ***
// Self-checking bench for the RTC status and event-pin block
`default_nettype none
module rtcsp_top_bench
   import rtcsp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [4:0] a;
      logic [7:0] d;
      logic [7:0] q;
   } rtcsp_row_t;
   localparam int WIN = int'(SAMPLE_TICKS) * 25 / 2;
   rtcsp_row_t rows [15] = '{
      '{REG_MINUTE, 8'h59, 8'h59}, '{REG_MINUTE, 8'h60, 8'h00},
      '{REG_MINUTE, 8'h5a, 8'h00}, '{REG_SECOND, 8'h75, 8'h00},
      '{REG_WDAY, 8'h07, 8'h00}, '{REG_WDAY, 8'h03, 8'h03},
      '{REG_YEAR, 8'h9a, 8'h00}, '{REG_MONTH, 8'h13, 8'h01},
      '{REG_MONTH, 8'h12, 8'h12}, '{REG_DAY, 8'h32, 8'h01},
      '{REG_HOUR, 8'h44, 8'h44}, '{REG_HOUR, 8'h48, 8'h00},
      '{REG_HOUR, 8'h46, 8'h46}, '{REG_FREE, 8'ha5, 8'ha5},
      '{5'h1f, 8'h5a, 8'h00}};
   logic       clk, osc_32k, supply_low, det, a_oe, b_oe;
   logic       rst = 1'b1, wr = 1'b0, rd = 1'b0, low_req = 1'b0;
   logic       ce = 1'b1;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00, rdata;
   int         error_cnt = 0, n_tests = 0, cyc = 0, t0, n;
   rtcsp_osc_model env (.low_req, .osc_32k, .supply_low);
   rtcsp_top dut (.clk, .rst, .ce, .osc_32k, .supply_low, .addr,
      .wdata, .wr, .rd, .rdata, .detector_sample(det),
      .event_pin_a_out(), .event_pin_a_oe(a_oe), .event_pin_b_out(),
      .event_pin_b_oe(b_oe));
   task automatic results;
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check8(input logic [7:0] g, e, input string m);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic check1(input logic g, e, input string m);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %0t %s got %b", $time, m, g);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [7:0] e,
                        input string m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check8(rdata, e, m);
   endtask
   task automatic wait_det(input logic v);
      n = 0;
      while (det !== v && n < 9000) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].q, "row");
      end
      wr_reg(REG_DAY, 8'h30);
      wr_reg(REG_MONTH, 8'h02);
      rdchk(REG_DAY, 8'h01, "eom day");
      rdchk(REG_MONTH, 8'h03, "eom month");
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rdchk(REG_STATUS1, 8'h01, "por s1");
      rdchk(REG_STATUS2, 8'h80, "por s2");
      rdchk(REG_PIN_A, 8'h80, "por freq");
      rdchk(REG_DAY, 8'h01, "por day");
      rdchk(REG_FREE, 8'h00, "por free");
      wait_det(1'b1);
      t0 = cyc;
      check1(det, 1'b1, "window open");
      @(posedge clk);
      low_req <= 1'b1;
      repeat (20) @(posedge clk);
      low_req <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check1(det, 1'b0, "sampling stops");
      rdchk(REG_STATUS1, 8'h03, "low flag");
      rdchk(REG_STATUS1, 8'h01, "flag read");
      check1(det, 1'b1, "sampling restarts");
      wait_det(1'b0);
      check1(cyc - t0 > WIN - 26 && cyc - t0 < WIN + 26, 1'b1, "win");
      wr_reg(REG_STATUS1, 8'h50);
      wr_reg(REG_STATUS1, 8'h80);
      rdchk(REG_STATUS1, 8'h50, "init s1");
      rdchk(REG_STATUS2, 8'h00, "init s2");
      rdchk(REG_PIN_A, 8'h00, "init pin a");
      rdchk(REG_MONTH, 8'h01, "init month");
      wr_reg(REG_PIN_A, 8'h00);
      wr_reg(REG_STATUS2, 8'h20);
      wr_reg(REG_PIN_A + 5'h2, 8'h01);
      settle();
      check1(a_oe, 1'b1, "alarm a");
      wr_reg(REG_STATUS2, 8'h00);
      wr_reg(REG_STATUS2, 8'h20);
      settle();
      check1(a_oe, 1'b0, "no refire");
      wr_reg(REG_STATUS2, 8'h40);
      settle();
      check1(a_oe, 1'b0, "edge waits");
      wr_reg(REG_PIN_B, 8'h00);
      wr_reg(REG_STATUS2, 8'h02);
      wr_reg(REG_PIN_B + 5'h2, 8'h01);
      settle();
      check1(b_oe, 1'b1, "alarm b");
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(REG_FREE, 8'h3c);
      ce <= 1'b1;
      rdchk(REG_FREE, 8'h00, "ce hold");
      results();
   end
endmodule
`default_nettype wire
